// file: rtl/aadm_dc_measure.sv
// AGC debounce setting, AGC gain report and DC measurement engine of the mono record path.
// ----------------------------------------------------------------
// Overview of operation
// - The four-bit debounce code selects zero, power-of-two or 2048-multiple sample intervals.
// - The gain the AGC applies is reported read-only as a signed half-decibel code.
// - Bit seven of the first control register enables DC measurement, reset disabled.
// - One control bit selects a sinc filter averaging over two to the power of the order.
// - The other method is a first-order IIR low-pass whose step follows the same order.
// - The order accepts one to twenty; other codes are reserved and are clamped here.
// - The freeze bit stops result updates so all three bytes stay consistent.
// - In IIR mode a bit selects instantaneous output or the value held before clearing.
// - The averaging-time code gives no clearing at zero or two to the n modulator periods.
// - The top result byte is read-only and resets to zero.
// - The middle and low result bytes are read-only and reset to zero.
// - Debounce intervals are counted in ADC sample periods.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module aadm_dc_measure
	import aadm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleStrobe,
	input wire logic modStrobe,
	input wire logic [23:0] adcSample,
	input wire logic [7:0] agcGain,
	input wire logic signalDetect,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic signalDebounced
);
	aadm_state_t st;
	aadm_state_t next_st;

	logic enable;
	logic iirMode;
	logic freeze;
	logic captureMode;
	logic [4:0] order;
	logic [4:0] avgCode;
	logic sincDone;
	logic clrNow;
	logic candValid;
	logic [23:0] candValue;
	logic [43:0] sincNext;
	logic [43:0] iirNext;
	logic [44:0] iirDiff;

	// ----------------------------------------------------------------
	// Control decode
	// ----------------------------------------------------------------
	always_comb
	begin
		enable = st.ctlOne[AADM_CTL1_ENABLE];
		iirMode = st.ctlOne[AADM_CTL1_IIR];
		freeze = st.ctlTwo[AADM_CTL2_FREEZE];
		captureMode = st.ctlTwo[AADM_CTL2_CAPTURE];
		order = st.ctlOne[4:0];
		if (order < AADM_ORDER_MIN)
			order = AADM_ORDER_MIN;
		else if (order > AADM_ORDER_MAX)
			order = AADM_ORDER_MAX;
		avgCode = st.ctlTwo[4:0];
		if (avgCode > AADM_ORDER_MAX)
			avgCode = AADM_ORDER_MAX;
	end

	// ----------------------------------------------------------------
	// Filter arithmetic
	// ----------------------------------------------------------------
	always_comb
	begin
		sincNext = st.sincSum + {{20{adcSample[23]}}, adcSample};
		sincDone = sampleStrobe && (st.sincCnt == aadm_mask(order));
		// One guard bit keeps a full-scale step against the opposite rail from wrapping.
		iirDiff = {adcSample[23], adcSample, 20'h00000} - {st.iirAcc[43], st.iirAcc};
		iirNext = st.iirAcc + 44'($signed(iirDiff) >>> order);
		clrNow = modStrobe && iirMode && (avgCode != 5'h00) &&
			(st.clrCnt == aadm_mask(avgCode));
		candValid = 1'b0;
		candValue = st.result;
		if (!iirMode)
		begin
			candValid = sincDone;
			candValue = 24'($signed(sincNext) >>> order);
		end
		else if (captureMode)
		begin
			candValid = clrNow;
			candValue = st.iirAcc[43:AADM_FRAC];
		end
		else if (sampleStrobe && !clrNow)
		begin
			candValid = 1'b1;
			candValue = iirNext[43:AADM_FRAC];
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		if (sampleStrobe)
			next_st.gainApplied = agcGain;
		if (regWrEn)
		begin
			unique case (regAddr)
				AADM_ADDR_DEBOUNCE: next_st.debounceCode = regWrData[3:0];
				AADM_ADDR_CTL_ONE: next_st.ctlOne = regWrData;
				AADM_ADDR_CTL_TWO: next_st.ctlTwo = regWrData;
				default: next_st.ctlOne = st.ctlOne;
			endcase
		end
		if (!enable)
		begin
			next_st.sincSum = '0;
			next_st.sincCnt = '0;
			next_st.iirAcc = '0;
			next_st.clrCnt = '0;
		end
		else
		begin
			if (sampleStrobe && !iirMode)
			begin
				next_st.sincSum = sincDone ? 44'h0 : sincNext;
				next_st.sincCnt = sincDone ? 21'h0 : st.sincCnt + 21'h000001;
			end
			if (iirMode)
			begin
				if (clrNow)
					next_st.iirAcc = '0;
				else if (sampleStrobe)
					next_st.iirAcc = iirNext;
				if (modStrobe && avgCode != 5'h00)
					next_st.clrCnt = clrNow ? 21'h0 : st.clrCnt + 21'h000001;
			end
			if (candValid && !freeze)
				next_st.result = candValue;
		end
		unique case (regAddr)
			AADM_ADDR_DEBOUNCE: next_st.rdData = {4'h0, st.debounceCode};
			AADM_ADDR_GAIN: next_st.rdData = st.gainApplied;
			AADM_ADDR_CTL_ONE: next_st.rdData = st.ctlOne;
			AADM_ADDR_CTL_TWO: next_st.rdData = st.ctlTwo;
			AADM_ADDR_RES_HIGH: next_st.rdData = st.result[23:16];
			AADM_ADDR_RES_MID: next_st.rdData = st.result[15:8];
			AADM_ADDR_RES_LOW: next_st.rdData = st.result[7:0];
			default: next_st.rdData = AADM_RSVD_READ;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.debounceCode <= AADM_DEBOUNCE_RST;
			st.ctlOne <= AADM_CTL_RST;
			st.ctlTwo <= AADM_CTL_RST;
			st.gainApplied <= AADM_GAIN_RST;
			st.result <= AADM_RESULT_RST;
		end
		else
			st <= next_st;
	end

	assign regRdData = st.rdData;

	// ----------------------------------------------------------------
	// Signal debounce
	// ----------------------------------------------------------------
	aadm_debounce debounceUnit (
		.clk(clk),
		.rst_n(rst_n),
		.sampleStrobe(sampleStrobe),
		.code(st.debounceCode),
		.levelIn(signalDetect),
		.levelOut(signalDebounced)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	disabled_hold_a: assert property (!enable |=> $stable(st.result))
		else $error("Result changed while measurement disabled.");
	freeze_hold_a: assert property (freeze && !regWrEn |=> $stable(st.result))
		else $error("Result changed while frozen.");
	gain_capture_a: assert property (sampleStrobe ##1 (regAddr == AADM_ADDR_GAIN)
		|=> regRdData == $past(agcGain, 2))
		else $error("Gain report did not follow the applied gain.");
	result_high_a: assert property ((regAddr == AADM_ADDR_RES_HIGH)
		|=> regRdData == $past(st.result[23:16]))
		else $error("Top result byte read wrong.");
	debounce_upper_a: assert property ((regAddr == AADM_ADDR_DEBOUNCE)
		|=> regRdData[7:4] == 4'h0)
		else $error("Reserved debounce bits not zero.");
	reserved_read_a: assert property ((regAddr >= AADM_ADDR_RSVD_FIRST &&
		regAddr <= AADM_ADDR_RSVD_LAST) |=> regRdData == AADM_RSVD_READ)
		else $error("Reserved register did not read zero.");
	enable_write_a: assert property ((regWrEn && regAddr == AADM_ADDR_CTL_ONE)
		|=> enable == $past(regWrData[AADM_CTL1_ENABLE]))
		else $error("Enable bit not taken from the write.");
	sinc_idle_a: assert property ((enable && !iirMode && !sincDone)
		|=> $stable(st.result))
		else $error("Sinc result moved before the window closed.");
	iir_inst_a: assert property ((enable && iirMode && !captureMode && !freeze &&
		sampleStrobe && !clrNow && !regWrEn) |=> st.result == st.iirAcc[43:AADM_FRAC])
		else $error("Instantaneous IIR result not shown.");
	iir_clear_a: assert property (clrNow && enable |=> st.iirAcc == 44'h0)
		else $error("IIR not cleared at end of averaging time.");

	sinc_update_c: cover property (enable && !iirMode && sincDone && !freeze);
	iir_clear_c: cover property (enable && iirMode && captureMode && clrNow);
	freeze_c: cover property (enable && freeze && candValid);
	debounce_c: cover property ($changed(signalDebounced));
endmodule
`default_nettype wire

// file: rtl/aadm_pkg.sv
// Constants, register map and state type for the ADC AGC and DC measurement block.
package aadm_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] AADM_ADDR_DEBOUNCE = 8'h5C;
	localparam logic [7:0] AADM_ADDR_GAIN = 8'h5D;
	localparam logic [7:0] AADM_ADDR_RSVD_FIRST = 8'h5E;
	localparam logic [7:0] AADM_ADDR_RSVD_LAST = 8'h65;
	localparam logic [7:0] AADM_ADDR_CTL_ONE = 8'h66;
	localparam logic [7:0] AADM_ADDR_CTL_TWO = 8'h67;
	localparam logic [7:0] AADM_ADDR_RES_HIGH = 8'h68;
	localparam logic [7:0] AADM_ADDR_RES_MID = 8'h69;
	localparam logic [7:0] AADM_ADDR_RES_LOW = 8'h6A;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int AADM_CTL1_ENABLE = 7;
	localparam int AADM_CTL1_IIR = 5;
	localparam int AADM_CTL2_FREEZE = 6;
	localparam int AADM_CTL2_CAPTURE = 5;
	localparam logic [3:0] AADM_DEBOUNCE_RST = 4'h0;
	localparam logic [7:0] AADM_CTL_RST = 8'h00;
	localparam logic [7:0] AADM_GAIN_RST = 8'h00;
	localparam logic [23:0] AADM_RESULT_RST = 24'h000000;
	localparam logic [7:0] AADM_RSVD_READ = 8'h00;

	// ----------------------------------------------------------------
	// Filter and debounce limits
	// ----------------------------------------------------------------
	localparam logic [4:0] AADM_ORDER_MIN = 5'h01;
	localparam logic [4:0] AADM_ORDER_MAX = 5'h14;
	localparam logic [3:0] AADM_DEB_POW_LAST = 4'h9;
	localparam logic [3:0] AADM_DEB_MULT_BASE = 4'h8;
	localparam logic [3:0] AADM_DEB_MULT_MAX = 4'h6;
	localparam int AADM_DEB_MULT_SHIFT = 11;
	localparam int AADM_FRAC = 20;

	// Debounce interval in ADC sample periods for a four-bit code.
	function automatic logic [13:0] aadm_debounce_len(input logic [3:0] code);
		logic [3:0] mult;
		mult = 4'h0;
		if (code == 4'h0)
			return 14'h0000;
		if (code <= AADM_DEB_POW_LAST)
			return 14'h0001 << (code + 4'h1);
		mult = code - AADM_DEB_MULT_BASE;
		if (mult > AADM_DEB_MULT_MAX)
			mult = AADM_DEB_MULT_MAX;
		return 14'({mult, 11'h000});
	endfunction

	// Terminal count mask for a period of two to the power of code.
	function automatic logic [20:0] aadm_mask(input logic [4:0] code);
		return (21'h000001 << code) - 21'h000001;
	endfunction

	typedef struct packed {
		logic [3:0] debounceCode;
		logic [7:0] ctlOne;
		logic [7:0] ctlTwo;
		logic [7:0] gainApplied;
		logic [23:0] result;
		logic [43:0] sincSum;
		logic [20:0] sincCnt;
		logic [43:0] iirAcc;
		logic [20:0] clrCnt;
		logic [7:0] rdData;
	} aadm_state_t;

	typedef struct packed {
		logic level;
		logic [13:0] cnt;
	} aadm_deb_state_t;
endpackage

// file: rtl/aadm_debounce.sv
// Signal debounce for the AGC signal-detect level, counted in ADC sample periods.
`timescale 1ns/1ps
`default_nettype none
module aadm_debounce
	import aadm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleStrobe,
	input wire logic [3:0] code,
	input wire logic levelIn,
	output logic levelOut
);
	aadm_deb_state_t st;
	aadm_deb_state_t next_st;

	always_comb
	begin
		next_st = st;
		if (levelIn == st.level)
			next_st.cnt = 14'h0000;
		else if (st.cnt >= aadm_debounce_len(code))
		begin
			next_st.level = levelIn;
			next_st.cnt = 14'h0000;
		end
		else if (sampleStrobe)
			next_st.cnt = st.cnt + 14'h0001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign levelOut = st.level;

	deb_zero_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		(code == 4'h0 && levelIn != levelOut && st.cnt == 14'h0000) |=> levelOut == $past(levelIn))
		else $error("Debounce code zero did not pass the level at once.");
endmodule
`default_nettype wire

// file: bench/aadm_dc_measure_tb.sv
// Self-checking testbench for the AGC debounce, gain report and DC measurement block.
`timescale 1ns/1ps
`default_nettype none
module aadm_dc_measure_tb
	import aadm_pkg::*;
;
	logic clk;
	logic rst_n;
	logic sampleStrobe;
	logic modStrobe;
	logic [23:0] adcSample;
	logic [7:0] agcGain;
	logic signalDetect;
	logic [7:0] regAddr;
	logic regWrEn;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic signalDebounced;
	int badCount;
	int checked;

	aadm_dc_measure u_dut (.clk(clk), .rst_n(rst_n), .sampleStrobe(sampleStrobe),
		.modStrobe(modStrobe), .adcSample(adcSample), .agcGain(agcGain),
		.signalDetect(signalDetect), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdData(regRdData), .signalDebounced(signalDebounced));

	always #5 clk = ~clk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			badCount++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		@(posedge clk);
		#1 d = regRdData;
	endtask

	task automatic rdRes(input logic [23:0] exp);
		logic [7:0] h;
		logic [7:0] m;
		logic [7:0] l;
		rd(AADM_ADDR_RES_HIGH, h);
		rd(AADM_ADDR_RES_MID, m);
		rd(AADM_ADDR_RES_LOW, l);
		chk({h, m, l}, exp);
	endtask

	task automatic strobe(input logic [23:0] x);
		@(posedge clk);
		sampleStrobe <= 1'b1;
		adcSample <= x;
		@(posedge clk);
		sampleStrobe <= 1'b0;
	endtask

	task automatic mod();
		@(posedge clk);
		modStrobe <= 1'b1;
		@(posedge clk);
		modStrobe <= 1'b0;
	endtask

	task automatic waitDeb(input logic exp);
		repeat (2) @(posedge clk);
		#1 chk(signalDebounced, exp);
	endtask

	task automatic wrRd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		logic [7:0] v;
		wr(a, d);
		rd(a, v);
		chk(v, exp);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic testReset();
		logic [7:0] addrs [10] = '{8'h5C, 8'h5D, 8'h5E, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69,
			8'h6A, 8'hFF};
		logic [7:0] v;
		foreach (addrs[i])
		begin
			rd(addrs[i], v);
			chk(v, 24'h000000);
		end
		chk(signalDebounced, 1'b0);
		$display("test reset done");
	endtask

	task automatic testRegs();
		logic [7:0] v;
		wrRd(AADM_ADDR_DEBOUNCE, 8'h0B, 8'h0B);
		wrRd(AADM_ADDR_CTL_ONE, 8'h34, 8'h34);
		wrRd(AADM_ADDR_CTL_TWO, 8'h65, 8'h65);
		wrRd(AADM_ADDR_GAIN, 8'h55, 8'h00);
		wrRd(AADM_ADDR_RES_HIGH, 8'hAA, 8'h00);
		wrRd(AADM_ADDR_RES_LOW, 8'hAA, 8'h00);
		rd(AADM_ADDR_RSVD_FIRST, v);
		chk(v, 24'h000000);
		wr(AADM_ADDR_CTL_ONE, 8'h00);
		wr(AADM_ADDR_CTL_TWO, 8'h00);
		$display("test registers done");
	endtask

	task automatic testGain();
		@(posedge clk);
		agcGain <= 8'hE8;
		strobe(24'h0);
		wrRd(AADM_ADDR_GAIN, 8'h00, 8'hE8);
		@(posedge clk);
		agcGain <= 8'h77;
		wrRd(AADM_ADDR_GAIN, 8'h00, 8'hE8);
		strobe(24'h0);
		wrRd(AADM_ADDR_GAIN, 8'h00, 8'h77);
		$display("test gain done");
	endtask

	task automatic testDebounce();
		wr(AADM_ADDR_DEBOUNCE, 8'h01);
		@(posedge clk);
		signalDetect <= 1'b1;
		repeat (3) strobe(24'h0);
		waitDeb(1'b0);
		strobe(24'h0);
		waitDeb(1'b1);
		wr(AADM_ADDR_DEBOUNCE, 8'h00);
		@(posedge clk);
		signalDetect <= 1'b0;
		waitDeb(1'b0);
		wr(AADM_ADDR_DEBOUNCE, 8'h0A);
		@(posedge clk);
		signalDetect <= 1'b1;
		repeat (4095) strobe(24'h0);
		waitDeb(1'b0);
		strobe(24'h0);
		waitDeb(1'b1);
		$display("test debounce done");
	endtask

	task automatic testSinc();
		wr(AADM_ADDR_CTL_ONE, 8'h81);
		strobe(24'd4);
		strobe(24'd6);
		rdRes(24'h000005);
		wr(AADM_ADDR_CTL_TWO, 8'h40);
		repeat (2) strobe(24'd100);
		rdRes(24'h000005);
		wr(AADM_ADDR_CTL_TWO, 8'h00);
		wr(AADM_ADDR_CTL_ONE, 8'h01);
		repeat (2) strobe(24'd50);
		rdRes(24'h000005);
		wr(AADM_ADDR_CTL_ONE, 8'h82);
		repeat (3) strobe(24'hFFFFFC);
		rdRes(24'h000005);
		strobe(24'hFFFFF8);
		rdRes(24'hFFFFFB);
		$display("test sinc done");
	endtask

	task automatic testIir();
		wr(AADM_ADDR_CTL_ONE, 8'h21);
		wr(AADM_ADDR_CTL_ONE, 8'hA1);
		strobe(24'd4);
		rdRes(24'h000002);
		strobe(24'd4);
		rdRes(24'h000003);
		wr(AADM_ADDR_CTL_ONE, 8'h21);
		wr(AADM_ADDR_CTL_TWO, 8'h21);
		wr(AADM_ADDR_CTL_ONE, 8'hA1);
		strobe(24'd8);
		rdRes(24'h000003);
		mod();
		rdRes(24'h000003);
		mod();
		rdRes(24'h000004);
		wr(AADM_ADDR_CTL_TWO, 8'h20);
		strobe(24'd8);
		repeat (4) mod();
		rdRes(24'h000004);
		$display("test iir done");
	endtask

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		sampleStrobe = 1'b0;
		modStrobe = 1'b0;
		adcSample = 24'h000000;
		agcGain = 8'h00;
		signalDetect = 1'b0;
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		badCount = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		testReset();
		testRegs();
		testGain();
		testDebounce();
		testSinc();
		testIir();
		summarize();
	end

	initial
	begin
		#200000;
		badCount++;
		summarize();
	end
endmodule
`default_nettype wire
